//--- cpd_pkg.sv
// shared constants and types for the coprocessor instruction dialog
package cpd_pkg;
   // coprocessor interface register selects
   localparam logic [2:0] SEL_RESPONSE   = 3'h0;
   localparam logic [2:0] SEL_CONTROL    = 3'h1;
   localparam logic [2:0] SEL_SAVE       = 3'h2;
   localparam logic [2:0] SEL_RESTORE    = 3'h3;
   localparam logic [2:0] SEL_COMMAND    = 3'h4;
   localparam logic [2:0] SEL_CONDITION  = 3'h5;
   localparam logic [2:0] SEL_OPERAND    = 3'h6;
   // bus cycle: acknowledge in the fourth clock of a cycle
   localparam logic [1:0] BUS_ACK_CNT    = 2'h2;
   // main processor passes its counter in two clocks
   localparam logic [1:0] PC_PASS_CLOCKS = 2'h2;
   localparam logic [1:0] PC_PASS_LAST   = PC_PASS_CLOCKS - 2'h1;
   // operand hand-off to the execution unit after the write cycle ends
   localparam logic [2:0] HANDOFF_CLOCKS = 3'h3;
   localparam logic [2:0] HANDOFF_LOAD   = HANDOFF_CLOCKS + 3'h1;
   // response primitive layout, low half of the read word
   localparam int         PRIM_CA_BIT    = 15;
   localparam int         PRIM_PC_BIT    = 14;
   localparam int         PRIM_IA_BIT    = 13;
   localparam int         PRIM_FUNC_LSB  = 8;
   localparam int         PRIM_COND_BIT  = 0;
   localparam logic [4:0] FUNC_NULL      = 5'h00;
   localparam logic [4:0] FUNC_EVAL_XFER = 5'h10;
   // command word operation class
   localparam int         OPC_MSB        = 15;
   localparam int         OPC_LSB        = 13;
   localparam logic [2:0] OPC_MEM_IN     = 3'h2;
   // predicate layout: [3:0] condition mask, [4] invert
   localparam int         PRED_INV_BIT   = 4;
   // state frame format byte, top of the save and restore word
   localparam int         FMT_LSB        = 24;
   localparam logic [7:0] FMT_NULL       = 8'h00;
   localparam logic [7:0] FMT_NOT_READY  = 8'h01;
   localparam logic [7:0] FMT_INVALID    = 8'h02;
   localparam logic [7:0] FMT_IDLE       = 8'h10;
   localparam logic [7:0] FMT_BUSY       = 8'h20;
   // controller register port
   localparam logic [3:0] REG_CMD        = 4'h0;
   localparam logic [3:0] REG_OPERAND    = 4'h1;
   localparam logic [3:0] REG_STATUS     = 4'h2;
   localparam logic [3:0] REG_MASK       = 4'h3;
   localparam logic [3:0] REG_RESULT     = 4'h4;
   localparam logic [3:0] REG_STATE      = 4'h5;
   localparam int         CMD_KIND_LSB   = 16;
   localparam int         ST_DONE_BIT    = 0;
   localparam int         ST_BAD_BIT     = 1;
   localparam logic [1:0] STATUS_RESET   = 2'h0;
   localparam logic [1:0] MASK_RESET     = 2'h0;
   typedef enum logic [1:0] {
      KIND_GEN     = 2'h0,
      KIND_COND    = 2'h1,
      KIND_SAVE    = 2'h2,
      KIND_RESTORE = 2'h3
   } cpd_kind_type;
   typedef enum logic [2:0] {
      D_IDLE    = 3'b000,
      D_STARTUP = 3'b001,
      D_XFER    = 3'b011,
      D_HANDOFF = 3'b010,
      D_COND    = 3'b110
   } cpd_dev_state_type;
   typedef enum logic [3:0] {
      H_IDLE    = 4'b0000,
      H_CMD_WR  = 4'b0001,
      H_RESP_RD = 4'b0011,
      H_PASS_PC = 4'b0010,
      H_OPND_WR = 4'b0110,
      H_COND_WR = 4'b0111,
      H_SAVE_RD = 4'b0101,
      H_REST_WR = 4'b0100,
      H_REST_RD = 4'b1100
   } cpd_host_state_type;
endpackage

//--- cpd_bus_if.sv
// coprocessor interface bus between main processor and coprocessor
`timescale 1ns/100ps
interface cpd_bus_if;
   logic        cyc;
   logic        wr;
   logic [2:0]  sel;
   logic [31:0] wdata;
   logic        ack;
   logic [31:0] rdata;
   modport dev (input cyc, input wr, input sel, input wdata, output ack, output rdata);
   modport cpu (output cyc, output wr, output sel, output wdata, input ack, input rdata);
endinterface

//--- cpd_device.sv
// coprocessor end of the instruction dialog
`timescale 1ns/100ps
module cpd_device
   import cpd_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst_b,
   cpd_bus_if.dev           bus,
   input  wire logic        exc_enable,
   input  wire logic        exec_busy,
   input  wire logic        save_point,
   input  wire logic [3:0]  fpcc,
   output logic             exec_start,
   output logic             conv_start,
   output logic [31:0]      operand_out,
   output logic [15:0]      command_out,
   output logic             save_suspend,
   output logic             resume,
   output logic             frame_reset
);

   cpd_dev_state_type state;
   cpd_dev_state_type next_state;
   logic [1:0]  cnt;
   logic [2:0]  hcnt;
   logic [5:0]  pred;
   logic [31:0] restore_word;
   logic        suspended;
   logic        used;
   logic        take;
   logic        take_rd;
   logic        take_wr;
   logic [31:0] rd_word;
   logic        start_now;
   logic        suspend_now;
   logic        resume_now;
   logic        reset_now;
   logic        opnd_now;

   function automatic logic [31:0] prim(input logic [4:0] func,
                                        input logic ca,
                                        input logic pc,
                                        input logic ia);
      logic [31:0] w;
      w = 32'h0;
      w[PRIM_CA_BIT] = ca;
      w[PRIM_PC_BIT] = pc;
      w[PRIM_IA_BIT] = ia;
      w[PRIM_FUNC_LSB +: 5] = func;
      return w;
   endfunction

   function automatic logic [31:0] frame(input logic [7:0] fmt);
      logic [31:0] w;
      w = 32'h0;
      w[FMT_LSB +: 8] = fmt;
      return w;
   endfunction

   // a condition is true when any masked code bit is set, optionally inverted
   function automatic logic pred_true(input logic [5:0] p, input logic [3:0] cc);
      return (|(p[3:0] & cc)) ^ p[PRED_INV_BIT];
   endfunction

   // every cycle is answered in its fourth clock; decisions are made one edge before
   assign take    = bus.cyc && !bus.ack && (cnt == BUS_ACK_CNT);
   assign take_rd = take && !bus.wr;
   assign take_wr = take && bus.wr;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= 2'h0;
      end else if (!bus.cyc || bus.ack) begin
         cnt <= 2'h0;
      end else if (cnt != BUS_ACK_CNT) begin
         cnt <= cnt + 2'h1;
      end
   end

   always_comb begin
      next_state  = state;
      rd_word     = 32'h0;
      start_now   = 1'b0;
      suspend_now = 1'b0;
      resume_now  = 1'b0;
      reset_now   = 1'b0;
      opnd_now    = 1'b0;
      if (state == D_HANDOFF && hcnt == 3'h1) begin
         next_state = D_IDLE;
      end
      if (take_rd) begin
         if (bus.sel == SEL_RESPONSE) begin
            case (state)
               D_STARTUP: begin
                  if (exec_busy) begin
                     rd_word = prim(FUNC_NULL, 1'b1, 1'b0, 1'b1);
                  end else if (command_out[OPC_MSB:OPC_LSB] == OPC_MEM_IN) begin
                     // come-again always set: the processor must poll again after the operand
                     rd_word    = prim(FUNC_EVAL_XFER, 1'b1, exc_enable, 1'b0);
                     next_state = D_XFER;
                  end else begin
                     rd_word    = prim(FUNC_NULL, 1'b0, 1'b0, 1'b0);
                     start_now  = 1'b1;
                     next_state = D_IDLE;
                  end
               end
               D_XFER, D_HANDOFF: begin
                  rd_word = prim(FUNC_NULL, 1'b1, 1'b0, 1'b1);
               end
               D_COND: begin
                  rd_word = prim(FUNC_NULL, 1'b0, 1'b0, 1'b0);
                  rd_word[PRIM_COND_BIT] = pred_true(pred, fpcc);
                  next_state = D_IDLE;
               end
               default: begin
                  rd_word = prim(FUNC_NULL, 1'b0, 1'b0, 1'b0);
               end
            endcase
         end else if (bus.sel == SEL_SAVE) begin
            if (exec_busy && !save_point) begin
               rd_word = frame(FMT_NOT_READY);
            end else if (exec_busy) begin
               rd_word     = frame(FMT_BUSY);
               suspend_now = 1'b1;
            end else if (used) begin
               rd_word = frame(FMT_IDLE);
            end else begin
               rd_word = frame(FMT_NULL);
            end
         end else if (bus.sel == SEL_RESTORE) begin
            // validate the format written by the processor
            case (restore_word[FMT_LSB +: 8])
               FMT_NULL: begin
                  rd_word    = restore_word;
                  reset_now  = 1'b1;
                  next_state = D_IDLE;
               end
               FMT_IDLE: begin
                  rd_word = restore_word;
               end
               FMT_BUSY: begin
                  rd_word    = restore_word;
                  resume_now = suspended;
               end
               default: begin
                  rd_word = frame(FMT_INVALID);
               end
            endcase
         end
      end else if (take_wr) begin
         if (bus.sel == SEL_COMMAND) begin
            next_state = D_STARTUP;
         end else if (bus.sel == SEL_CONDITION) begin
            next_state = D_COND;
         end else if (bus.sel == SEL_OPERAND && state == D_XFER) begin
            next_state = D_HANDOFF;
            opnd_now   = 1'b1;
         end else if (bus.sel == SEL_CONTROL) begin
            next_state = D_IDLE;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state <= D_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         bus.ack   <= 1'b0;
         bus.rdata <= 32'h0;
      end else begin
         bus.ack <= take;
         if (take_rd) begin
            bus.rdata <= rd_word;
         end
      end
   end

   // hand-off counter: conversion may only begin once the operand is inside
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         hcnt <= 3'h0;
      end else if (opnd_now) begin
         hcnt <= HANDOFF_LOAD;
      end else if (hcnt != 3'h0) begin
         hcnt <= hcnt - 3'h1;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         command_out  <= 16'h0;
         operand_out  <= 32'h0;
         pred         <= 6'h0;
         restore_word <= 32'h0;
      end else if (take_wr) begin
         if (bus.sel == SEL_COMMAND) begin
            command_out <= bus.wdata[15:0];
         end
         if (opnd_now) begin
            operand_out <= bus.wdata;
         end
         if (bus.sel == SEL_CONDITION) begin
            pred <= bus.wdata[5:0];
         end
         if (bus.sel == SEL_RESTORE) begin
            restore_word <= bus.wdata;
         end
      end
   end

   // suspension survives until a busy frame is restored or the unit is reset
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         suspended <= 1'b0;
         used      <= 1'b0;
      end else begin
         if (suspend_now) begin
            suspended <= 1'b1;
         end else if (resume_now || reset_now) begin
            suspended <= 1'b0;
         end
         if (take_wr && bus.sel == SEL_COMMAND) begin
            used <= 1'b1;
         end else if (reset_now) begin
            used <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         exec_start   <= 1'b0;
         conv_start   <= 1'b0;
         save_suspend <= 1'b0;
         resume       <= 1'b0;
         frame_reset  <= 1'b0;
      end else begin
         exec_start   <= start_now;
         conv_start   <= (state == D_HANDOFF) && (hcnt == 3'h1);
         save_suspend <= suspend_now;
         resume       <= resume_now;
         frame_reset  <= reset_now;
      end
   end

endmodule // cpd_device

//--- cpd_host.sv
// main processor end of the instruction dialog, driven by a register port
`timescale 1ns/100ps
module cpd_host
   import cpd_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   output logic             irq,
   cpd_bus_if.cpu           bus
);

   cpd_host_state_type state;
   cpd_kind_type       kind;
   logic [15:0] cmd_word;
   logic [31:0] operand;
   logic [31:0] result;
   logic [1:0]  status;
   logic [1:0]  mask;
   logic [1:0]  pc_cnt;
   logic        go;
   logic        is_bus;
   logic        cur_wr;
   logic [2:0]  cur_sel;
   logic [31:0] cur_data;
   logic        fin;
   logic        bad;
   logic        bus_done;

   assign go       = reg_wr && (reg_addr == REG_CMD) && (state == H_IDLE);
   assign bus_done = bus.cyc && bus.ack;

   always_comb begin
      is_bus   = 1'b1;
      cur_wr   = 1'b0;
      cur_sel  = SEL_RESPONSE;
      cur_data = 32'h0;
      case (state)
         H_CMD_WR: begin
            cur_wr   = 1'b1;
            cur_sel  = SEL_COMMAND;
            cur_data = {16'h0, cmd_word};
         end
         H_COND_WR: begin
            cur_wr   = 1'b1;
            cur_sel  = SEL_CONDITION;
            cur_data = {16'h0, cmd_word};
         end
         H_OPND_WR: begin
            cur_wr   = 1'b1;
            cur_sel  = SEL_OPERAND;
            cur_data = operand;
         end
         H_REST_WR: begin
            cur_wr   = 1'b1;
            cur_sel  = SEL_RESTORE;
            cur_data = operand;
         end
         H_REST_RD: cur_sel = SEL_RESTORE;
         H_SAVE_RD: cur_sel = SEL_SAVE;
         H_RESP_RD: cur_sel = SEL_RESPONSE;
         default:   is_bus = 1'b0;
      endcase
   end

   // one idle clock separates bus cycles so every cycle has a visible end
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         bus.cyc   <= 1'b0;
         bus.wr    <= 1'b0;
         bus.sel   <= SEL_RESPONSE;
         bus.wdata <= 32'h0;
      end else if (is_bus && !bus.cyc) begin
         bus.cyc   <= 1'b1;
         bus.wr    <= cur_wr;
         bus.sel   <= cur_sel;
         bus.wdata <= cur_data;
      end else if (bus_done) begin
         bus.cyc <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state  <= H_IDLE;
         pc_cnt <= 2'h0;
         fin    <= 1'b0;
         bad    <= 1'b0;
      end else begin
         fin <= 1'b0;
         bad <= 1'b0;
         case (state)
            H_IDLE: begin
               if (go) begin
                  case (cpd_kind_type'(reg_wdata[CMD_KIND_LSB +: 2]))
                     KIND_GEN:  state <= H_CMD_WR;
                     KIND_COND: state <= H_COND_WR;
                     KIND_SAVE: state <= H_SAVE_RD;
                     default:   state <= H_REST_WR;
                  endcase
               end
            end
            H_CMD_WR, H_COND_WR, H_OPND_WR: begin
               if (bus_done) begin
                  state <= H_RESP_RD;
               end
            end
            H_RESP_RD: begin
               if (bus_done) begin
                  if (bus.rdata[PRIM_FUNC_LSB +: 5] == FUNC_EVAL_XFER) begin
                     state  <= bus.rdata[PRIM_PC_BIT] ? H_PASS_PC : H_OPND_WR;
                     pc_cnt <= 2'h0;
                  end else if (!bus.rdata[PRIM_CA_BIT]) begin
                     state <= H_IDLE;
                     fin   <= 1'b1;
                  end
               end
            end
            H_PASS_PC: begin
               pc_cnt <= pc_cnt + 2'h1;
               if (pc_cnt == PC_PASS_LAST) begin
                  state <= H_OPND_WR;
               end
            end
            H_SAVE_RD: begin
               if (bus_done && bus.rdata[FMT_LSB +: 8] != FMT_NOT_READY) begin
                  state <= H_IDLE;
                  fin   <= 1'b1;
               end
            end
            H_REST_WR: begin
               if (bus_done) begin
                  state <= H_REST_RD;
               end
            end
            H_REST_RD: begin
               if (bus_done) begin
                  state <= H_IDLE;
                  fin   <= 1'b1;
                  bad   <= (bus.rdata[FMT_LSB +: 8] == FMT_INVALID);
               end
            end
            default: state <= H_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cmd_word <= 16'h0;
         kind     <= KIND_GEN;
         operand  <= 32'h0;
         mask     <= MASK_RESET;
      end else if (reg_wr) begin
         if (go) begin
            cmd_word <= reg_wdata[15:0];
            kind     <= cpd_kind_type'(reg_wdata[CMD_KIND_LSB +: 2]);
         end else if (reg_addr == REG_OPERAND && state == H_IDLE) begin
            operand <= reg_wdata;
         end else if (reg_addr == REG_MASK) begin
            mask <= reg_wdata[1:0];
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         result <= 32'h0;
      end else if (bus_done && !bus.wr) begin
         result <= bus.rdata;
      end
   end

   // a new event wins over a simultaneous write-one clear
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         status <= STATUS_RESET;
      end else begin
         status <= (status & ~((reg_wr && reg_addr == REG_STATUS) ? reg_wdata[1:0] : 2'h0))
                   | {bad, fin};
      end
   end

   assign irq = |(status & mask);

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 32'h0;
      end else if (!reg_rd) begin
         reg_rdata <= 32'h0;
      end else if (reg_addr == REG_CMD) begin
         reg_rdata <= {14'h0, kind, cmd_word};
      end else if (reg_addr == REG_OPERAND) begin
         reg_rdata <= operand;
      end else if (reg_addr == REG_STATUS) begin
         reg_rdata <= {30'h0, status};
      end else if (reg_addr == REG_MASK) begin
         reg_rdata <= {30'h0, mask};
      end else if (reg_addr == REG_RESULT) begin
         reg_rdata <= result;
      end else if (reg_addr == REG_STATE) begin
         reg_rdata <= {27'h0, state, state != H_IDLE};
      end else begin
         reg_rdata <= 32'h0;
      end
   end

endmodule // cpd_host

//--- cpd_monitor.sv
// protocol checker on the dialog bus between the two ends
`timescale 1ns/100ps
module cpd_monitor
   import cpd_pkg::*;
(
   input wire logic        clock,
   input wire logic        rst_b,
   input wire logic        cyc,
   input wire logic        wr,
   input wire logic [2:0]  sel,
   input wire logic        ack,
   input wire logic [31:0] rdata,
   input wire logic        exc_enable,
   input wire logic        exec_start,
   input wire logic        conv_start
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   logic resp;
   logic eval;
   logic opw;
   assign resp = ack && !wr && sel == SEL_RESPONSE;
   assign eval = resp && rdata[12:8] == FUNC_EVAL_XFER;
   assign opw  = ack && wr && sel == SEL_OPERAND;
   a_ack_fourth_clock: assert property (
      $rose(cyc) |-> !ack ##1 !ack ##1 !ack ##1 ack) else $error("ack out of place");
   a_cyc_held: assert property (
      cyc && !ack |=> cyc && $stable(wr) && $stable(sel)) else $error("cycle not held");
   a_cyc_release: assert property (
      ack |=> !cyc) else $error("cycle not released");
   a_restore_quiet: assert property (
      ack && !wr && sel == SEL_RESTORE |=> !cyc [*3])
      else $error("dialog reopened after restore");
   a_exec_on_read: assert property (
      exec_start |-> resp && !rdata[PRIM_CA_BIT]) else $error("start outside read");
   a_eval_flags: assert property (
      eval |-> rdata[PRIM_CA_BIT] && rdata[PRIM_PC_BIT] == exc_enable)
      else $error("transfer flags wrong");
   a_counter_pass: assert property (
      eval && rdata[PRIM_PC_BIT] |=> !cyc [*3] ##[1:4] (cyc && wr && sel == SEL_OPERAND))
      else $error("counter pass wrong");
   a_handoff_delay: assert property (
      opw |-> !conv_start [*4] ##1 conv_start) else $error("hand-off late or early");
   a_conv_cause: assert property (
      conv_start |-> $past(opw, 4)) else $error("conversion without operand");
   a_null_wait_flags: assert property (
      resp && rdata[PRIM_CA_BIT] && rdata[12:8] == FUNC_NULL |-> rdata[PRIM_IA_BIT])
      else $error("wait null lacks flag");
   c_exec: cover property (exec_start);
   c_conv: cover property (conv_start);
   c_pass: cover property (eval && rdata[PRIM_PC_BIT]);
   c_wait: cover property (resp && rdata[PRIM_CA_BIT] && rdata[12:8] == FUNC_NULL);
endmodule // cpd_monitor

//--- coproc_instruction_dialog_tb.sv
// self-checking bench: host and device joined over the dialog bus
`timescale 1ns/100ps
module coproc_instruction_dialog_tb
   import cpd_pkg::*;
;
   logic        clock, rst_b, reg_wr, reg_rd, irq, exc_enable, exec_busy, save_point;
   logic        exec_start, conv_start, save_suspend, resume, frame_reset;
   logic [3:0]  reg_addr, fpcc;
   logic [15:0] command_out;
   logic [31:0] reg_wdata, reg_rdata, operand_out, rd, st, w;
   logic [31:0] seed = 32'h464D;
   int          err_count, compares, n_exec, n_conv, n_susp, n_res, n_frst;
   cpd_bus_if cpd_bus_if_inst ();
   cpd_host cpd_host_inst (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .irq(irq), .bus(cpd_bus_if_inst));
   cpd_device cpd_device_inst (.clock(clock), .rst_b(rst_b), .bus(cpd_bus_if_inst),
      .exc_enable(exc_enable), .exec_busy(exec_busy), .save_point(save_point),
      .fpcc(fpcc), .exec_start(exec_start), .conv_start(conv_start),
      .operand_out(operand_out), .command_out(command_out),
      .save_suspend(save_suspend), .resume(resume), .frame_reset(frame_reset));
   cpd_monitor cpd_monitor_inst (.clock(clock), .rst_b(rst_b),
      .cyc(cpd_bus_if_inst.cyc), .wr(cpd_bus_if_inst.wr), .sel(cpd_bus_if_inst.sel),
      .ack(cpd_bus_if_inst.ack), .rdata(cpd_bus_if_inst.rdata), .exc_enable(exc_enable),
      .exec_start(exec_start), .conv_start(conv_start));
   always @(posedge clock) begin
      n_exec <= n_exec + int'(exec_start);
      n_conv <= n_conv + int'(conv_start);
      n_susp <= n_susp + int'(save_suspend);
      n_res  <= n_res + int'(resume);
      n_frst <= n_frst + int'(frame_reset);
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clock);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 rd = reg_rdata;
   endtask
   // polls the status word; bounded so a stuck dialog shows as a mismatch
   task automatic wait_done();
      int i;
      i = 0;
      rd_reg(REG_STATUS);
      while (rd[ST_DONE_BIT] !== 1'b1 && i < 200) begin
         rd_reg(REG_STATUS);
         i++;
      end
      st = rd;
      check(32'(rd[ST_DONE_BIT]), 32'h1);
   endtask
   task automatic run(input cpd_kind_type k, input logic [15:0] cw);
      wr_reg(REG_CMD, {14'h0, k, cw});
      wait_done();
      wr_reg(REG_STATUS, 32'h3);
      rd_reg(REG_RESULT);
   endtask
   task automatic print_verdict();
      $display("mismatches %0d comparisons %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   initial begin
      repeat (30000) @(posedge clock);
      err_count++;
      print_verdict();
   end
   initial begin
      {rst_b, reg_wr, reg_rd, exc_enable, exec_busy, save_point} = 6'h0;
      {reg_addr, fpcc, reg_wdata} = 40'h0;
      {err_count, compares} = '0;
      repeat (5) @(posedge clock);
      rst_b <= 1'b1;
      rd_reg(REG_STATUS);
      check(rd, 32'h0);
      rd_reg(REG_MASK);
      check(rd, 32'h0);
      rd_reg(4'hF);
      check(rd, 32'h0);
      for (int k = 0; k < 4; k++) begin
         w = rnd();
         w[OPC_MSB:OPC_LSB] = 3'h0;
         run(KIND_GEN, w[15:0]);
         check(32'(command_out), 32'(w[15:0]));
         check(32'(rd[PRIM_CA_BIT]), 32'h0);
         check(n_exec, k + 1);
      end
      for (int k = 0; k < 4; k++) begin
         exc_enable <= k[0];
         w = rnd();
         wr_reg(REG_OPERAND, w);
         run(KIND_GEN, {OPC_MEM_IN, w[12:0]});
         check(operand_out, w);
         check(n_conv, k + 1);
      end
      // a busy unit at start-up must stall the dialog with waiting nulls
      exec_busy <= 1'b1;
      wr_reg(REG_CMD, 32'h0);
      repeat (40) @(posedge clock);
      rd_reg(REG_STATUS);
      check(32'(rd[ST_DONE_BIT]), 32'h0);
      rd_reg(REG_STATE);
      check(32'(rd[0]), 32'h1);
      exec_busy <= 1'b0;
      wait_done();
      wr_reg(REG_STATUS, 32'h3);
      for (int k = 0; k < 8; k++) begin
         w = rnd();
         fpcc <= w[23:20];
         run(KIND_COND, {11'h0, w[4:0]});
         check(32'(rd[PRIM_COND_BIT]), 32'((|(w[3:0] & w[23:20])) ^ w[PRED_INV_BIT]));
      end
      run(KIND_SAVE, 16'h0);
      check(32'(rd[31:FMT_LSB]), 32'(FMT_IDLE));
      exec_busy <= 1'b1;
      wr_reg(REG_CMD, {14'h0, KIND_SAVE, 16'h0});
      repeat (40) @(posedge clock);
      rd_reg(REG_STATUS);
      check(32'(rd[ST_DONE_BIT]), 32'h0);
      save_point <= 1'b1;
      wait_done();
      wr_reg(REG_STATUS, 32'h3);
      rd_reg(REG_RESULT);
      check(32'(rd[31:FMT_LSB]), 32'(FMT_BUSY));
      check(n_susp, 1);
      exec_busy  <= 1'b0;
      save_point <= 1'b0;
      wr_reg(REG_OPERAND, rd);
      run(KIND_RESTORE, 16'h0);
      check(32'(st[ST_BAD_BIT]), 32'h0);
      check(n_res, 1);
      wr_reg(REG_OPERAND, 32'h7700_0000);
      run(KIND_RESTORE, 16'h0);
      check(32'(st[ST_BAD_BIT]), 32'h1);
      check(32'(rd[31:FMT_LSB]), 32'(FMT_INVALID));
      wr_reg(REG_OPERAND, {FMT_IDLE, 24'h0});
      run(KIND_RESTORE, 16'h0);
      check(32'(st[ST_BAD_BIT]), 32'h0);
      check(32'(rd[31:FMT_LSB]), 32'(FMT_IDLE));
      check(n_res, 1);
      wr_reg(REG_OPERAND, 32'h0);
      run(KIND_RESTORE, 16'h0);
      check(n_frst, 1);
      // done event: masked, then unmasked, then cleared
      wr_reg(REG_CMD, 32'h0);
      wait_done();
      check(32'(irq), 32'h0);
      wr_reg(REG_MASK, 32'h1);
      #1 check(32'(irq), 32'h1);
      wr_reg(REG_STATUS, 32'h1);
      #1 check(32'(irq), 32'h0);
      print_verdict();
   end
endmodule // coproc_instruction_dialog_tb
